// [plm_macrocell_array.sv]
// Function
// - OR gate sums chosen terms; cascade from previous cell extends to 40 terms.
// - Selector hands each of five terms to sum gates or cell controls.
// - XOR takes OR sum and a term or constant; constant sets polarity.
// - Flip-flop data from XOR output, separate term, or own pin.
// - Storage acts as D, T, JK or SR flip-flop via its type field.
// - Latch mode is transparent while clock high, holds while clock low.
// - Clock is one of three global clocks or a term; rising edge only.
// - With global clock, an enabled clock-enable term low blocks all edges.
// - Clear is global clear, a term, their OR, or off.
// - Preset is a term or off.
// - Output and buried feedback each pick registered or combinatorial, independently.
// - Output enable from either enable pin true/inverted, or a pin or cell.
// - Each pin input, output or both; input use keeps cell logic usable.
// - Global bus holds pins and 32 feedbacks; each block picks 40.
// - Each cell folds back one inverted term, shared by four cells.
// - Every term sees the block's global picks and its regional bus.
// - Four dedicated pins serve as clocks, clear or enables, mapped once for the whole array.
// - Keeper holds a released pin at its last driven level.
// - Sixteen-bit signature stays readable when security fuse is set.
//
// The register addresses and register access over Wishbone were left to the implementer.
module plm_macrocell_array
   import plm_pkg::*;
#(
   parameter logic [15:0] SIG_RESET = 16'h0000
)
(
   input wire logic clk,
   input wire logic rstn,
   input wire logic wb_cyc_i,
   input wire logic wb_stb_i,
   input wire logic wb_we_i,
   input wire logic [AW-1:0] wb_adr_i,
   input wire logic [31:0] wb_dat_i,
   input wire logic [3:0] wb_sel_i,
   output logic [31:0] wb_dat_o,
   output logic wb_ack_o,
   input wire logic [NC-1:0] io_in,
   output logic [NC-1:0] io_out,
   output logic [NC-1:0] io_oe,
   input wire logic [NDED-1:0] ded_in,
   output logic [NPIN-1:0] keep_out,
   output logic [NPIN-1:0] keep_oe
);

   plm_state_t st;
   plm_state_t next_st;

   logic [GBW-1:0] gbus;
   logic [NBLK-1:0][SMW-1:0] sm;
   logic [NGCK:0] global_clock_inputs;
   logic gclr;
   logic [1:0] oe_pin;
   logic [NC-1:0] sum_out;
   logic [NC-1:0] cell_out;
   logic [NC-1:0] fb_c;
   logic [NC-1:0] fold_c;
   logic [NC-1:0] oe_c;
   logic [NC-1:0] ff_nq;
   logic [NC-1:0] clk_v;

   // Byte-lane merge for Wishbone writes
   function automatic logic [31:0] lane_merge(
      input logic [31:0] old_w,
      input logic [31:0] new_w,
      input logic [3:0] sel
   );
      logic [31:0] r;
      r = old_w;
      for (int b = 0; b < 4; b++)
      begin
         if (sel[b])
         begin
            r[8*b +: 8] = new_w[8*b +: 8];
         end
      end
      return r;
   endfunction : lane_merge

   // Global bus: dedicated pins, I/O pins, buried feedback
   assign gbus = {st.fb, st.io_s2, st.ded_s2};

   // Dedicated pins mapped onto global control roles
   assign global_clock_inputs[0] = st.ded_s2[st.route.gck0];
   assign global_clock_inputs[1] = st.ded_s2[st.route.gck1];
   assign global_clock_inputs[2] = st.ded_s2[st.route.gck2];
   assign global_clock_inputs[NGCK] = 1'b0;
   assign gclr = st.ded_s2[st.route.gclr];
   assign oe_pin[0] = st.ded_s2[st.route.oe0];
   assign oe_pin[1] = st.ded_s2[st.route.oe1];

   // Switch matrix: each block picks SMW signals off the global bus
   for (genvar b = 0; b < NBLK; b++)
   begin : g_blk
      for (genvar j = 0; j < SMW; j++)
      begin : g_sm
         localparam int W = SM_BASE + b * SMWPB + j / SMPW;
         logic [GSW-1:0] idx;
         assign idx = st.cfg[W][(j % SMPW) * SMF +: GSW];
         // Out-of-range picks read low rather than X
         assign sm[b][j] = (idx < GSW'(GBW)) ? gbus[idx] : 1'b0;
      end
   end

   // One macrocell per iteration
   for (genvar i = 0; i < NC; i++)
   begin : g_cell
      plm_ctrl0_t c0;
      plm_ctrl1_t c1;
      logic [PIW-1:0] x;
      logic [NPT-1:0] pt;
      logic [PTSEL-1:0] px;
      logic casc;
      logic or_t;
      logic xin;
      logic xo;
      logic d;
      logic aux;
      logic ce;
      logic upd;
      logic fnext;
      logic clr;
      logic pre;
      logic ffv;
      logic oe;

      assign c0 = plm_ctrl0_t'(st.cfg[i * CW + C0_OFF]);
      assign c1 = plm_ctrl1_t'(st.cfg[i * CW + C1_OFF]);

      // Term inputs: block picks plus the regional foldback bus
      assign x = {st.fold[(i / NREG) * NREG +: NREG], sm[i / CPB]};

      // Product terms with true and complement literal masks
      for (genvar p = 0; p < NPT; p++)
      begin : g_pt
         localparam int B = i * CW + p * PT_WORDS;
         logic [PIW-1:0] t;
         logic [PIW-1:0] c;
         assign t = {st.cfg[B + 2][HI_T +: PHI], st.cfg[B]};
         assign c = {st.cfg[B + 2][HI_C +: PHI], st.cfg[B + 1]};
         // A term with no literals is disabled, so it reads low
         assign pt[p] = (|{t, c}) & (&(~t | x)) & (&(~c | ~x));
      end
      assign px = PTSEL'(pt);

      // Cascade chains restart every CHAIN cells
      if (i % CHAIN == 0)
      begin : g_head
         assign casc = 1'b0;
      end
      else
      begin : g_link
         assign casc = sum_out[i - 1];
      end

      // Sum term and XOR polarity
      assign or_t = (|(pt & c0.or_en)) | (c0.casc_en & casc);
      assign sum_out[i] = or_t;

      always_comb
      begin
         case (c0.xor_sel)
            XS_ZERO: xin = 1'b0;
            XS_ONE: xin = 1'b1;
            XS_PT: xin = px[c0.xor_pt];
            default: xin = 1'b0;
         endcase
      end
      assign xo = or_t ^ xin;

      // Data source
      always_comb
      begin
         case (c0.d_sel)
            DS_XOR: d = xo;
            DS_PT: d = px[c0.d_pt];
            DS_PIN: d = st.io_s2[i];
            default: d = xo;
         endcase
      end
      assign aux = px[c0.aux_pt];

      // Clock select, sampled as a level and edge-detected on clk
      assign clk_v[i] = (c1.clk_sel == CK_PT) ? px[c1.clk_pt]
                        : global_clock_inputs[c1.clk_sel];
      // Enable only applies to the global clocks
      assign ce = !(c1.clk_sel != CK_PT && c1.ce_en) | px[c1.ce_pt];
      assign upd = ce & (c0.latch ? clk_v[i]
                         : (clk_v[i] & ~st.clk_prev[i]));

      // Flip-flop type, T and JK via toggling the held value
      always_comb
      begin
         case (c0.ff_type)
            FF_D: fnext = d;
            FF_T: fnext = st.q[i] ^ d;
            FF_JK: fnext = (d & ~st.q[i]) | (~aux & st.q[i]);
            FF_SR: fnext = d | (~aux & st.q[i]);
            default: fnext = d;
         endcase
      end

      // Asynchronous clear and preset, clear dominant
      always_comb
      begin
         case (c1.clr_sel)
            CL_OFF: clr = 1'b0;
            CL_GLB: clr = gclr;
            CL_PT: clr = px[c1.clr_pt];
            CL_OR: clr = gclr | px[c1.clr_pt];
            default: clr = 1'b0;
         endcase
      end
      assign pre = c1.pre_en & px[c1.pre_pt];

      // Held value; an open latch shows data without waiting a cycle
      assign ffv = clr ? 1'b0
                 : pre ? 1'b1
                 : (c0.latch & upd) ? d
                 : st.q[i];
      assign ff_nq[i] = !st.ctrl.run ? 1'b0
                      : clr ? 1'b0
                      : pre ? 1'b1
                      : upd ? fnext
                      : st.q[i];

      // Output and buried feedback choose independently
      assign cell_out[i] = c1.out_reg ? ffv : xo;
      assign fb_c[i] = c1.fb_reg ? ffv : xo;
      assign fold_c[i] = ~px[c1.fold_pt];

      // Output enable select
      always_comb
      begin
         case (c1.oe_sel)
            OE_P0: oe = oe_pin[0];
            OE_P0N: oe = ~oe_pin[0];
            OE_P1: oe = oe_pin[1];
            OE_P1N: oe = ~oe_pin[1];
            OE_CELL: oe = cell_out[c1.oe_src];
            OE_PIN: oe = st.io_s2[c1.oe_src];
            OE_IN: oe = 1'b0;
            OE_ON: oe = 1'b1;
            default: oe = 1'b0;
         endcase
      end
      assign oe_c[i] = st.ctrl.run & oe;
   end

   // Next-state logic
   always_comb
   begin
      logic [CIW-1:0] cidx;
      logic hit;
      next_st = st;
      cidx = wb_adr_i[CFG_BIT-1:2];
      hit = wb_cyc_i & wb_stb_i & ~st.ack;

      // Two-stage synchronisers for pins
      next_st.io_s1 = io_in;
      next_st.io_s2 = st.io_s1;
      next_st.ded_s1 = ded_in;
      next_st.ded_s2 = st.ded_s1;

      // Cell state; feedback and foldback are sampled to break loops
      next_st.q = ff_nq;
      next_st.clk_prev = clk_v;
      next_st.fb = fb_c;
      next_st.fold = fold_c;
      next_st.io_out = cell_out;
      next_st.io_oe = oe_c;

      // Keeper tracks our drive, else the last level seen on the pin
      next_st.keep_lvl = {st.ded_s2, (oe_c & cell_out) | (~oe_c & st.io_s2)};
      next_st.keep_oe = st.ctrl.keeper ? {{NDED{1'b1}}, ~oe_c}
                                       : '0;

      // Wishbone slave, one wait state, ack lasts one cycle
      next_st.ack = hit;
      next_st.dat = '0;
      if (hit && !wb_we_i)
      begin
         if (wb_adr_i[CFG_BIT])
         begin
            // Fuse hides configuration but never the signature
            if (!st.ctrl.fuse && cidx < CIW'(CFG_WORDS))
            begin
               next_st.dat = st.cfg[cidx];
            end
         end
         else
         begin
            case (wb_adr_i[7:0])
               REG_CTRL: next_st.dat = st.ctrl;
               REG_SIG: next_st.dat = {16'h0000, st.sig};
               REG_ROUTE: next_st.dat = st.route;
               REG_PINS: next_st.dat = st.io_s2;
               REG_DED: next_st.dat = 32'(st.ded_s2);
               REG_FFQ: next_st.dat = st.q;
               REG_OE: next_st.dat = st.io_oe;
               default: next_st.dat = '0;
            endcase
         end
      end
      if (hit && wb_we_i)
      begin
         if (wb_adr_i[CFG_BIT])
         begin
            // Running logic never sees its setup change underneath it
            if (!st.ctrl.run && cidx < CIW'(CFG_WORDS))
            begin
               next_st.cfg[cidx] = lane_merge(st.cfg[cidx], wb_dat_i,
                                              wb_sel_i);
            end
         end
         else
         begin
            case (wb_adr_i[7:0])
               REG_CTRL:
               begin
                  next_st.ctrl = lane_merge(st.ctrl, wb_dat_i, wb_sel_i);
                  next_st.ctrl.rsv = '0;
                  // Fuse is set-only until reset
                  next_st.ctrl.fuse = next_st.ctrl.fuse | st.ctrl.fuse;
               end
               REG_SIG:
               begin
                  if (!st.ctrl.fuse)
                  begin
                     next_st.sig = 16'(lane_merge({16'h0000, st.sig},
                                                  wb_dat_i, wb_sel_i));
                  end
               end
               REG_ROUTE:
               begin
                  if (!st.ctrl.run)
                  begin
                     next_st.route = lane_merge(st.route, wb_dat_i,
                                                wb_sel_i);
                     next_st.route.rsv = '0;
                  end
               end
               default:
               begin
                  next_st.dat = '0;
               end
            endcase
         end
      end
   end

   // State register
   always_ff @(posedge clk or negedge rstn)
   begin
      if (!rstn)
      begin
         st <= '0;
         st.sig <= SIG_RESET;
      end
      else
      begin
         st <= next_st;
      end
   end

   // Outputs straight from state
   assign wb_ack_o = st.ack;
   assign wb_dat_o = st.dat;
   assign io_out = st.io_out;
   assign io_oe = st.io_oe;
   assign keep_out = st.keep_lvl;
   assign keep_oe = st.keep_oe;

endmodule : plm_macrocell_array

// [plm_pkg.sv]
package plm_pkg;

   // Array geometry
   localparam int NC = 32;
   localparam int NPT = 5;
   localparam int NDED = 4;
   localparam int NGCK = 3;
   localparam int NREG = 4;
   localparam int CHAIN = 8;
   localparam int CPB = 16;
   localparam int NBLK = 2;
   localparam int SMW = 40;
   localparam int NPIN = NC + NDED;
   localparam int GBW = NDED + 2 * NC;
   localparam int GSW = 7;
   localparam int PIW = SMW + NREG;
   localparam int PHI = PIW - 32;
   localparam int PTSEL = 8;

   // Configuration memory layout, in 32-bit words
   localparam int PT_WORDS = 3;
   localparam int C0_OFF = NPT * PT_WORDS;
   localparam int C1_OFF = C0_OFF + 1;
   localparam int CW = C1_OFF + 1;
   localparam int HI_T = 0;
   localparam int HI_C = 16;
   localparam int SMF = 8;
   localparam int SMPW = 4;
   localparam int SMWPB = SMW / SMPW;
   localparam int SM_BASE = NC * CW;
   localparam int CFG_WORDS = SM_BASE + NBLK * SMWPB;

   // Wishbone map
   localparam int AW = 14;
   localparam int CFG_BIT = 13;
   localparam int CIW = CFG_BIT - 2;
   localparam logic [7:0] REG_CTRL = 8'h00;
   localparam logic [7:0] REG_SIG = 8'h04;
   localparam logic [7:0] REG_ROUTE = 8'h08;
   localparam logic [7:0] REG_PINS = 8'h0c;
   localparam logic [7:0] REG_DED = 8'h10;
   localparam logic [7:0] REG_FFQ = 8'h14;
   localparam logic [7:0] REG_OE = 8'h18;

   typedef enum logic [1:0] {XS_ZERO, XS_ONE, XS_PT, XS_RSV} plm_xsel_t;
   typedef enum logic [1:0] {DS_XOR, DS_PT, DS_PIN, DS_RSV} plm_dsel_t;
   typedef enum logic [1:0] {FF_D, FF_T, FF_JK, FF_SR} plm_fft_t;
   typedef enum logic [1:0] {CK_G0, CK_G1, CK_G2, CK_PT} plm_csel_t;
   typedef enum logic [1:0] {CL_OFF, CL_GLB, CL_PT, CL_OR} plm_rsel_t;
   typedef enum logic [2:0] {
      OE_P0, OE_P0N, OE_P1, OE_P1N, OE_CELL, OE_PIN, OE_IN, OE_ON
   } plm_oesel_t;

   typedef struct packed {
      logic [9:0] rsv;
      logic latch;
      logic [2:0] aux_pt;
      plm_fft_t ff_type;
      logic [2:0] d_pt;
      plm_dsel_t d_sel;
      logic [2:0] xor_pt;
      plm_xsel_t xor_sel;
      logic casc_en;
      logic [NPT-1:0] or_en;
   } plm_ctrl0_t;

   typedef struct packed {
      logic rsv;
      logic [2:0] fold_pt;
      logic [4:0] oe_src;
      plm_oesel_t oe_sel;
      logic fb_reg;
      logic out_reg;
      logic [2:0] pre_pt;
      logic pre_en;
      logic [2:0] clr_pt;
      plm_rsel_t clr_sel;
      logic [2:0] ce_pt;
      logic ce_en;
      logic [2:0] clk_pt;
      plm_csel_t clk_sel;
   } plm_ctrl1_t;

   typedef struct packed {
      logic [28:0] rsv;
      logic keeper;
      logic fuse;
      logic run;
   } plm_ctrl_t;

   typedef struct packed {
      logic [19:0] rsv;
      logic [1:0] oe1;
      logic [1:0] oe0;
      logic [1:0] gclr;
      logic [1:0] gck2;
      logic [1:0] gck1;
      logic [1:0] gck0;
   } plm_route_t;

   typedef struct packed {
      logic [CFG_WORDS-1:0][31:0] cfg;
      plm_ctrl_t ctrl;
      logic [15:0] sig;
      plm_route_t route;
      logic [NC-1:0] io_s1;
      logic [NC-1:0] io_s2;
      logic [NDED-1:0] ded_s1;
      logic [NDED-1:0] ded_s2;
      logic [NC-1:0] q;
      logic [NC-1:0] clk_prev;
      logic [NC-1:0] fb;
      logic [NC-1:0] fold;
      logic [NC-1:0] io_out;
      logic [NC-1:0] io_oe;
      logic [NPIN-1:0] keep_lvl;
      logic [NPIN-1:0] keep_oe;
      logic ack;
      logic [31:0] dat;
   } plm_state_t;

endpackage : plm_pkg

// [plm_sva.sv]
module plm_sva
   import plm_pkg::*;
#(
   parameter logic [15:0] SIG_RESET = 16'h0000
)
(
   input wire logic clk,
   input wire logic rstn,
   input wire logic wb_cyc_i,
   input wire logic wb_stb_i,
   input wire logic wb_we_i,
   input wire logic [AW-1:0] wb_adr_i,
   input wire logic [31:0] wb_dat_i,
   input wire logic [3:0] wb_sel_i,
   input wire logic [31:0] wb_dat_o,
   input wire logic wb_ack_o,
   input wire logic [NC-1:0] io_oe,
   input wire logic [NPIN-1:0] keep_oe
);
   timeunit 1ns;
   timeprecision 1ps;
   logic [15:0] sig_sh;
   logic fuse_sh, run_sh, keep_sh;
   logic wr_ok;
   logic rd_ok;

   assign wr_ok = wb_ack_o && wb_we_i;
   assign rd_ok = wb_ack_o && !wb_we_i;

   // Shadow of control bits; fuse is set-only
   always_ff @(posedge clk or negedge rstn)
   begin
      if (!rstn)
         {sig_sh, fuse_sh, run_sh, keep_sh} <= {SIG_RESET, 3'b000};
      else if (wr_ok && wb_adr_i == 14'(REG_CTRL) && wb_sel_i[0])
         {keep_sh, fuse_sh, run_sh} <=
            {wb_dat_i[2], wb_dat_i[1] | fuse_sh, wb_dat_i[0]};
      else if (wr_ok && wb_adr_i == 14'(REG_SIG) && !fuse_sh
               && wb_sel_i[1:0] == 2'b11)
         sig_sh <= wb_dat_i[15:0];
   end

   default clocking cb @(posedge clk); endclocking
   default disable iff (!rstn);

   AST_ACK_NEXT: assert property (
      wb_cyc_i && wb_stb_i && !wb_ack_o |=> wb_ack_o)
      else $error("no ack one cycle after request");
   AST_ACK_PULSE: assert property (
      wb_ack_o |=> !wb_ack_o)
      else $error("ack longer than one cycle");
   AST_ACK_CAUSE: assert property (
      wb_ack_o |-> $past(wb_cyc_i) && $past(wb_stb_i))
      else $error("ack without request");
   AST_DAT_IDLE: assert property (
      !wb_ack_o |-> wb_dat_o == 32'h0)
      else $error("read data outside ack");
   AST_SIG_READ: assert property (
      rd_ok && wb_adr_i == 14'(REG_SIG) |-> wb_dat_o == {16'h0, sig_sh})
      else $error("signature read wrong");
   AST_CFG_HIDE: assert property (
      rd_ok && wb_adr_i[CFG_BIT] && fuse_sh |-> wb_dat_o == 32'h0)
      else $error("config readable under fuse");
   AST_STOP_OE: assert property (
      !run_sh |-> io_oe == '0)
      else $error("pin driven while stopped");
   AST_KEEP_OFF: assert property (
      !keep_sh |-> keep_oe == '0)
      else $error("keeper active while disabled");
endmodule : plm_sva

bind plm_macrocell_array plm_sva #(.SIG_RESET(SIG_RESET)) plm_sva_i (
   .clk, .rstn, .wb_cyc_i, .wb_stb_i, .wb_we_i, .wb_adr_i, .wb_dat_i,
   .wb_sel_i, .wb_dat_o, .wb_ack_o, .io_oe, .keep_oe);

// [plm_board.sv]
module plm_board
   import plm_pkg::*;
(
   input wire logic clk,
   input wire logic [NC-1:0] io_out,
   input wire logic [NC-1:0] io_oe,
   input wire logic [NPIN-1:0] keep_out,
   input wire logic [NPIN-1:0] keep_oe,
   input wire logic [NPIN-1:0] drv_en,
   input wire logic [NPIN-1:0] drv_val,
   output logic [NPIN-1:0] pin
);
   timeunit 1ns;
   timeprecision 1ps;
   logic [NPIN-1:0] last = '0;

   // Device wins, then board, then keeper; a bare line wanders
   always_comb
   begin
      for (int i = 0; i < NPIN; i++)
      begin
         if (i < NC && io_oe[i % NC])
            pin[i] = io_out[i % NC];
         else if (drv_en[i])
            pin[i] = drv_val[i];
         else if (keep_oe[i])
            pin[i] = keep_out[i];
         else
            pin[i] = ~last[i];
      end
   end

   // Floating level flips every cycle, never a stale copy
   always_ff @(posedge clk)
      last <= pin;
endmodule : plm_board

// [plm_macrocell_array_tb.sv]
module plm_macrocell_array_tb
   import plm_pkg::*;
();
   timeunit 1ns;
   timeprecision 1ps;
   localparam logic [15:0] SIG0 = 16'h3c5a; // Arbitrary value
   logic clk = 1'b0;
   logic rstn = 1'b0;
   logic cyc = 1'b0, stb = 1'b0, we = 1'b0;
   logic [AW-1:0] adr = '0;
   logic [31:0] dat = '0, rdat;
   logic [3:0] sel = '0;
   logic ack;
   logic [NC-1:0] io_out, io_oe, io_in;
   logic [NDED-1:0] ded_in;
   logic [NPIN-1:0] keep_out, keep_oe, pin;
   logic [NPIN-1:0] drv_en = 36'hf_0000_0006;
   logic [NPIN-1:0] drv_val = '0;
   int err_total = 0;
   int checks = 0;

   assign io_in = pin[NC-1:0];
   assign ded_in = pin[NPIN-1:NC];

   plm_macrocell_array #(.SIG_RESET(SIG0)) plm_macrocell_array_i (
      .clk(clk), .rstn(rstn), .wb_cyc_i(cyc), .wb_stb_i(stb),
      .wb_we_i(we), .wb_adr_i(adr), .wb_dat_i(dat), .wb_sel_i(sel),
      .wb_dat_o(rdat), .wb_ack_o(ack), .io_in(io_in), .io_out(io_out),
      .io_oe(io_oe), .ded_in(ded_in), .keep_out(keep_out),
      .keep_oe(keep_oe));

   plm_board plm_board_i (
      .clk(clk), .io_out(io_out), .io_oe(io_oe), .keep_out(keep_out),
      .keep_oe(keep_oe), .drv_en(drv_en), .drv_val(drv_val), .pin(pin));

   initial
   begin
      forever #20 clk = ~clk;
   end

   task automatic close_out;
      if (err_total == 0 && checks > 0)
         $display("== PASSED ==");
      else
         $display("== FAILED ==");
      $finish;
   endtask : close_out

   task automatic chk(input logic [31:0] g, input logic [31:0] e);
      checks++;
      if (g !== e)
      begin
         err_total++;
         $display("ERROR %0t got %h exp %h", $time, g, e);
      end
   endtask : chk

   // One classic cycle; holds everything until ack is sampled
   task automatic bus(input logic w, input logic [13:0] a,
                      input logic [31:0] d, output logic [31:0] q);
      int n;
      @(posedge clk);
      {cyc, stb, we, adr, dat, sel} <= {2'b11, w, a, d, 4'hf};
      n = 0;
      do
      begin
         @(posedge clk);
         n++;
      end
      while (ack !== 1'b1 && n < 50);
      q = rdat;
      {cyc, stb, we} <= 3'b000;
      if (n >= 50)
      begin
         err_total++;
         $display("ERROR %0t bus timeout", $time);
         close_out;
      end
   endtask : bus

   task automatic wr(input logic [13:0] a, input logic [31:0] d);
      logic [31:0] q;
      bus(1'b1, a, d, q);
   endtask : wr

   task automatic rd(input logic [13:0] a, input logic [31:0] e);
      logic [31:0] q;
      bus(1'b0, a, 32'h0, q);
      chk(q, e);
   endtask : rd

   function automatic logic [13:0] ca(input int i);
      return {1'b1, 11'(i), 2'b00};
   endfunction : ca

   task automatic pin_set(input int b, input logic v);
      @(posedge clk);
      drv_val[b] <= v;
   endtask : pin_set

   // Bounded wait on one output bit, then compare
   task automatic wait_out(input int b, input logic e);
      int n;
      n = 0;
      while (io_out[b] !== e && n < 10)
      begin
         @(posedge clk);
         n++;
      end
      chk(32'(io_out[b]), 32'(e));
      // A wait that ran out ends the run
      if (io_out[b] !== e)
      begin
         close_out;
      end
   endtask : wait_out

   // Global clock pulse on dedicated pin 0, past the synchroniser
   task automatic pulse;
      pin_set(NC, 1'b1);
      repeat (4) @(posedge clk);
      pin_set(NC, 1'b0);
      repeat (4) @(posedge clk);
   endtask : pulse

   task automatic t_reset;
      rd(14'(REG_CTRL), 32'h0);
      rd(14'(REG_SIG), {16'h0, SIG0});
      rd(14'h001c, 32'h0);
   endtask : t_reset

   // Cell 0 sums one term on pin 1, output always on
   task automatic t_comb;
      wr(ca(SM_BASE), 32'h05);
      wr(ca(0), 32'h1);
      wr(ca(C0_OFF), 32'h1);
      wr(ca(C1_OFF), 32'h0070_0000);
      wr(14'(REG_CTRL), 32'h1);
      pin_set(1, 1'b1);
      wait_out(0, 1'b1);
      chk(32'(io_oe[0]), 32'h1);
      pin_set(1, 1'b0);
      wait_out(0, 1'b0);
      wr(ca(C0_OFF), 32'h41);
      rd(ca(C0_OFF), 32'h1);
      wr(14'(REG_CTRL), 32'h0);
      wr(ca(C0_OFF), 32'h41);
      wr(14'(REG_CTRL), 32'h1);
      wait_out(0, 1'b1);
   endtask : t_comb

   // Registered output on global clock 0: enable, clock, clear
   task automatic t_reg;
      wr(14'(REG_CTRL), 32'h0);
      wr(ca(C0_OFF), 32'h1);
      wr(ca(C1_OFF), 32'h0074_0060);
      // Output enable 0 on idle pin 3, so no cell fights the bench on pin 1
      wr(14'(REG_ROUTE), 32'h300);
      wr(14'(REG_CTRL), 32'h1);
      pin_set(1, 1'b1);
      pulse;
      chk(32'(io_out[0]), 32'h0);
      wr(14'(REG_CTRL), 32'h0);
      wr(ca(C1_OFF), 32'h0074_0200);
      wr(14'(REG_ROUTE), 32'h340);
      wr(14'(REG_CTRL), 32'h1);
      repeat (4) @(posedge clk);
      chk(32'(io_out[0]), 32'h0);
      pulse;
      wait_out(0, 1'b1);
      rd(14'(REG_FFQ), 32'h1);
      pin_set(NC + 1, 1'b1);
      wait_out(0, 1'b0);
      pin_set(NC + 1, 1'b0);
   endtask : t_reg

   task automatic t_keep;
      wr(14'(REG_CTRL), 32'h5);
      for (int v = 1; v >= 0; v--)
      begin
         @(posedge clk);
         drv_en[2] <= 1'b1;
         pin_set(2, v[0]);
         repeat (4) @(posedge clk);
         drv_en[2] <= 1'b0;
         repeat (4) @(posedge clk);
         chk(32'(keep_oe[2]), 32'h1);
         chk(32'(io_in[2]), 32'(v[0]));
      end
   endtask : t_keep

   // Cell 0 as latch on global clock 0: open follows, closed holds
   task automatic t_latch;
      wr(14'(REG_CTRL), 32'h0);
      wr(ca(C0_OFF), 32'h0020_0001);
      wr(ca(C1_OFF), 32'h0074_0000);
      wr(14'(REG_CTRL), 32'h1);
      repeat (4) @(posedge clk);
      chk(32'(io_out[0]), 32'h0);
      pin_set(NC, 1'b1);
      wait_out(0, 1'b1);
      pin_set(1, 1'b0);
      wait_out(0, 1'b0);
      pin_set(1, 1'b1);
      wait_out(0, 1'b1);
      // Data falls one cycle after the clock, so the latch must hold
      pin_set(NC, 1'b0);
      pin_set(1, 1'b0);
      repeat (6) @(posedge clk);
      chk(32'(io_out[0]), 32'h1);
   endtask : t_latch

   // Cell 0 as toggle flip-flop, preset by a term on dedicated pin 2
   task automatic t_toggle;
      wr(14'(REG_CTRL), 32'h0);
      wr(ca(SM_BASE), 32'h0205);
      wr(ca(3), 32'h2);
      wr(ca(C0_OFF), 32'h0001_0001);
      wr(ca(C1_OFF), 32'h0074_c000);
      wr(14'(REG_CTRL), 32'h1);
      pin_set(1, 1'b1);
      pulse;
      wait_out(0, 1'b1);
      pulse;
      wait_out(0, 1'b0);
      pin_set(NC + 2, 1'b1);
      wait_out(0, 1'b1);
      pin_set(NC + 2, 1'b0);
   endtask : t_toggle

   // Cascade into cell 1 and foldback into cell 3; cell 1 follows pin 1, cell 3 follows it inverted
   task automatic t_chain;
      wr(14'(REG_CTRL), 32'h0);
      wr(ca(CW + C0_OFF), 32'h20);
      wr(ca(CW + C1_OFF), 32'h0060_0000);
      wr(ca(3 * CW + 2), 32'h100);
      wr(ca(3 * CW + C0_OFF), 32'h1);
      wr(ca(3 * CW + C1_OFF), 32'h0010_0000);
      wr(14'(REG_CTRL), 32'h1);
      for (int v = 1; v >= 0; v--)
      begin
         pin_set(1, v[0]);
         wait_out(1, v[0]);
         wait_out(3, ~v[0]);
      end
      chk(32'(io_oe[3]), 32'h1);
   endtask : t_chain

   task automatic t_sig;
      wr(14'(REG_SIG), 32'h0000_9e61);
      rd(14'(REG_SIG), 32'h0000_9e61);
      wr(14'(REG_CTRL), 32'h3);
      wr(14'(REG_SIG), 32'h0000_1111);
      rd(14'(REG_SIG), 32'h0000_9e61);
      rd(ca(0), 32'h0);
   endtask : t_sig

   initial
   begin
      repeat (16) @(posedge clk);
      rstn <= 1'b1;
      t_reset;
      t_comb;
      t_reg;
      t_keep;
      t_latch;
      t_toggle;
      t_chain;
      t_sig;
      close_out;
   end
endmodule : plm_macrocell_array_tb
